// >>> shared/hbp_pkg.sv
/*
 Constants and types for the host parallel bus port: register map size,
 interrupt source layout, reset values and handshake timing.
 Assumes one 25 MHz system clock and a synchronous active-high reset.
*/
package hbp_pkg;
   localparam int unsigned HBP_ADDR_W      = 8;
   localparam int unsigned HBP_DATA_W      = 8;
   localparam int unsigned HBP_NUM_REGS    = 16;
   localparam int unsigned HBP_SRC_W       = 8;
   // Command register space, offsets 0x00..0x0D are plain read/write
   localparam logic [7:0]  HBP_OFS_IRQ_EN  = 8'h0E;
   localparam logic [7:0]  HBP_OFS_IRQ_SRC = 8'h0F;
   localparam logic [7:0]  HBP_CMD_RESET   = 8'h00;
   localparam logic [7:0]  HBP_EN_RESET    = 8'h00;
   localparam logic [7:0]  HBP_DATA_IDLE   = 8'h00;
   // Extra cycles spent in DONE before ready goes low, so read data is out first
   localparam int unsigned HBP_SYNC_STAGES = 3;
   localparam logic [1:0]  HBP_RDY_LAT     = 2'h1;

   typedef enum logic [3:0] {
      HBP_IDLE   = 4'b0001,
      HBP_ACCESS = 4'b0010,
      HBP_DONE   = 4'b0100,
      HBP_WAIT   = 4'b1000
   } hbp_state_t;

   function automatic logic hbp_reg_hit(input logic [7:0] addr);
      return addr < HBP_NUM_REGS[7:0];
   endfunction : hbp_reg_hit
endpackage : hbp_pkg

// >>> shared/hbp_pin_if.sv
/*
 Interface carrying the synchronised host strobes between the pin
 synchroniser and the bus port core. Assumes one clock domain.
*/
`timescale 1ns/1ps
interface hbp_pin_if;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic rst_n;
   modport sync (output cs_n, output rd_n, output wr_n, output rst_n);
   modport core (input cs_n, input rd_n, input wr_n, input rst_n);
endinterface : hbp_pin_if

// >>> core/hbp_pin_sync.sv
/*
 Three-stage synchroniser for the asynchronous host control pins.
 A level change is accepted once the second and third stages agree;
 the first stage feeds only the second. Assumes sys_clk at 25 MHz.
*/
`timescale 1ns/1ps
module hbp_pin_sync
   import hbp_pkg::*;
(
   input  wire logic  sys_clk,
   input  wire logic  sys_rst,
   input  wire logic  cs_n_pin,
   input  wire logic  rd_n_pin,
   input  wire logic  wr_n_pin,
   input  wire logic  rst_n_pin,
   hbp_pin_if.sync    pins
);
   logic [3:0] stage1;
   logic [3:0] stage2;
   logic [3:0] stage3;
   logic [3:0] agreed;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stage1 <= 4'hF;
         stage2 <= 4'hF;
         stage3 <= 4'hF;
      end else begin
         stage1 <= {rst_n_pin, wr_n_pin, rd_n_pin, cs_n_pin};
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Hold the last agreed level while stages two and three disagree
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         agreed <= 4'hF;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (stage2[i] == stage3[i]) begin
               agreed[i] <= stage3[i];
            end
         end
      end
   end

   assign pins.cs_n  = agreed[0];
   assign pins.rd_n  = agreed[1];
   assign pins.wr_n  = agreed[2];
   assign pins.rst_n = agreed[3];
endmodule : hbp_pin_sync

// >>> core/hbp_host_port.sv
/*
 Host parallel bus port: eight-bit address, bidirectional data with
 separate in/out/enable, active-low strobes, ready handshake, interrupt
 with read-to-clear sources, and reset pin that restores command registers.
 Assumes the host holds address and write data stable while a strobe is low
 and keeps the strobe low until ready is seen.
*/
`timescale 1ns/1ps

// Overview of operation
// - Eight address lines choose the register each read or write targets.
// - Eight data lines carry write data in and read data out.
// - Interrupt output rests high while no enabled source is pending.
// - An enabled source that occurs pulls the interrupt output low.
// - Reading the source register clears its flags; interrupt rises unless others pend.
// - A low pulse on the reset pin restores all command registers.
// - Chip select low with a read or write strobe low starts an access; high means the bus is idle.
// - Write strobe stores data into the addressed register.
// - Read strobe places the addressed register contents on the data bus.
// - Ready goes low when the access completes; host waits for it.
module hbp_host_port
   import hbp_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire logic [HBP_ADDR_W-1:0] addr,
   input  wire logic [HBP_DATA_W-1:0] data_in,
   output logic      [HBP_DATA_W-1:0] data_out,
   output logic                       data_oe,
   input  wire logic                  cs_n,
   input  wire logic                  rd_n,
   input  wire logic                  wr_n,
   output logic                       rdy_n,
   output logic                       int_n,
   input  wire logic                  reset_n,
   input  wire logic [HBP_SRC_W-1:0]  irq_event,
   output logic [HBP_NUM_REGS*HBP_DATA_W-1:0] cmd_regs
);
   hbp_pin_if  pins ();
   hbp_state_t state;
   hbp_state_t next_state;
   logic [HBP_DATA_W-1:0] regs [HBP_NUM_REGS];
   logic [HBP_SRC_W-1:0]  irq_en;
   logic [HBP_SRC_W-1:0]  irq_src;
   logic [HBP_ADDR_W-1:0] addr_q [HBP_SYNC_STAGES];
   logic [HBP_DATA_W-1:0] data_q [HBP_SYNC_STAGES];
   logic [HBP_SRC_W-1:0]  event_q [HBP_SYNC_STAGES];
   logic                  dev_rst;
   logic                  is_read;
   logic                  src_clear;
   logic [1:0]            rdy_cnt;

   hbp_pin_sync u_sync (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .cs_n_pin  (cs_n),
      .rd_n_pin  (rd_n),
      .wr_n_pin  (wr_n),
      .rst_n_pin (reset_n),
      .pins      (pins.sync)
   );

   // Address, data and event lines come from outside; same three-stage treatment
   // Only the last stage is read; the host holds these steady before any strobe
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < HBP_SYNC_STAGES; i++) begin
            addr_q[i]  <= 8'h00;
            data_q[i]  <= 8'h00;
            event_q[i] <= 8'h00;
         end
      end else begin
         addr_q[0]  <= addr;
         data_q[0]  <= data_in;
         event_q[0] <= irq_event;
         for (int i = 1; i < HBP_SYNC_STAGES; i++) begin
            addr_q[i]  <= addr_q[i-1];
            data_q[i]  <= data_q[i-1];
            event_q[i] <= event_q[i-1];
         end
      end
   end

   // The pad pull-up keeps an undriven pin high; the synchroniser also resets high,
   // so no device reset fires by itself once the system reset is released
   assign dev_rst = sys_rst | ~pins.rst_n;

   // Access sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         HBP_IDLE: begin
            if (!pins.cs_n && (!pins.rd_n || !pins.wr_n)) begin
               next_state = HBP_ACCESS;
            end
         end
         HBP_ACCESS: next_state = HBP_DONE;
         HBP_DONE: begin
            if (rdy_cnt == 2'h0) begin
               next_state = HBP_WAIT;
            end
         end
         HBP_WAIT: begin
            // Either a deselect or the release of both strobes ends the access
            if (pins.cs_n || (pins.rd_n && pins.wr_n)) begin
               next_state = HBP_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= HBP_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Direction is captured while idle; a strobe swap in mid-access is ignored
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         is_read <= 1'b0;
      end else if (state == HBP_IDLE) begin
         is_read <= ~pins.rd_n;
      end
   end

   // Reloaded while idle so every access waits the same number of cycles
   always_ff @(posedge sys_clk) begin
      if (sys_rst || state == HBP_IDLE) begin
         rdy_cnt <= HBP_RDY_LAT;
      end else if (state == HBP_DONE && rdy_cnt != 2'h0) begin
         rdy_cnt <= rdy_cnt - 2'h1;
      end
   end

   // Command registers and interrupt enable
   // Writes to the source register or past the map are dropped
   always_ff @(posedge sys_clk) begin
      if (dev_rst) begin
         for (int i = 0; i < HBP_NUM_REGS; i++) begin
            regs[i] <= HBP_CMD_RESET;
         end
         irq_en <= HBP_EN_RESET;
      end else if (state == HBP_ACCESS && !is_read) begin
         if (addr_q[2] == HBP_OFS_IRQ_EN) begin
            irq_en <= data_q[2];
         end else if (hbp_reg_hit(addr_q[2]) && addr_q[2] != HBP_OFS_IRQ_SRC) begin
            regs[addr_q[2][3:0]] <= data_q[2];
         end
      end
   end

   // The enable and source slots show those flops, so the whole map is visible
   always_comb begin
      for (int i = 0; i < HBP_NUM_REGS; i++) begin
         cmd_regs[i*HBP_DATA_W +: HBP_DATA_W] = regs[i];
      end
      cmd_regs[HBP_OFS_IRQ_EN*HBP_DATA_W +: HBP_DATA_W]  = irq_en;
      cmd_regs[HBP_OFS_IRQ_SRC*HBP_DATA_W +: HBP_DATA_W] = irq_src;
   end

   // Source flags; an event in the clearing cycle survives the clear
   assign src_clear = state == HBP_ACCESS && is_read && addr_q[2] == HBP_OFS_IRQ_SRC;
   always_ff @(posedge sys_clk) begin
      if (dev_rst) begin
         irq_src <= 8'h00;
      end else if (src_clear) begin
         irq_src <= event_q[2] & irq_en;
      end else begin
         irq_src <= irq_src | (event_q[2] & irq_en);
      end
   end

   // Follows the flags one edge later; clearing an enable also releases the pin
   always_ff @(posedge sys_clk) begin
      if (dev_rst) begin
         int_n <= 1'b1;
      end else begin
         int_n <= ~|(irq_src & irq_en);
      end
   end

   // Read data is latched once, so a late source clear never disturbs it
   always_ff @(posedge sys_clk) begin
      if (dev_rst) begin
         data_out <= HBP_DATA_IDLE;
      end else if (state == HBP_ACCESS && is_read) begin
         if (addr_q[2] == HBP_OFS_IRQ_EN) begin
            data_out <= irq_en;
         end else if (addr_q[2] == HBP_OFS_IRQ_SRC) begin
            data_out <= irq_src;
         end else if (hbp_reg_hit(addr_q[2])) begin
            data_out <= regs[addr_q[2][3:0]];
         end else begin
            data_out <= HBP_DATA_IDLE;
         end
      end
   end

   // Follows the synchronised strobes, so the bus is let go a few cycles after
   // the host releases; a host must allow for that turnaround
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= ~pins.cs_n & ~pins.rd_n & is_read & (state != HBP_IDLE);
      end
   end

   // Decided from next_state so ready changes on the edge the state moves
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdy_n <= 1'b1;
      end else begin
         rdy_n <= ~(next_state == HBP_WAIT);
      end
   end
endmodule : hbp_host_port

// >>> testbench/hbp_host_port_assertions.sv
/* Pin-level checker for the host bus port.
   Assumes it is bound to hbp_host_port and sees only its ports. */
`timescale 1ns/1ps
module hbp_host_port_assertions
   import hbp_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [7:0]   addr,
   input  wire logic [7:0]   data_in,
   input  wire logic [7:0]   data_out,
   input  wire logic         data_oe,
   input  wire logic         cs_n,
   input  wire logic         rd_n,
   input  wire logic         wr_n,
   input  wire logic         rdy_n,
   input  wire logic         int_n,
   input  wire logic         reset_n,
   input  wire logic [7:0]   irq_event,
   input  wire logic [127:0] cmd_regs
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_write; $fell(rdy_n) && !wr_n && addr < 8'h0F |-> cmd_regs[{addr[3:0], 3'h0} +: 8] == data_in; endproperty
   a_write: assert property (p_write) else $error("write not stored");
   property p_read; $fell(rdy_n) && !rd_n && addr < 8'h0F |-> data_out == cmd_regs[{addr[3:0], 3'h0} +: 8]; endproperty
   a_read: assert property (p_read) else $error("read data wrong");
   property p_taken; !cs_n && ($fell(rd_n) || $fell(wr_n)) |-> ##[4:10] !rdy_n; endproperty
   a_taken: assert property (p_taken) else $error("ready late");
   property p_idle; cs_n [*8] |-> rdy_n && !data_oe; endproperty
   a_idle: assert property (p_idle) else $error("bus busy while deselected");
   property p_oe; $rose(data_oe) |-> !cs_n && !rd_n && wr_n; endproperty
   a_oe: assert property (p_oe) else $error("data driven outside read");
   property p_int_set; |(irq_event & cmd_regs[119:112]) |-> ##[1:8] !int_n; endproperty
   a_int_set: assert property (p_int_set) else $error("interrupt not raised");
   property p_src_clr; $fell(rdy_n) && !rd_n && addr == HBP_OFS_IRQ_SRC && irq_event == 8'h00 |-> ##[0:4] int_n;
   endproperty
   a_src_clr: assert property (p_src_clr) else $error("interrupt not cleared");
   property p_rst_pin; $fell(reset_n) |-> ##[3:8] cmd_regs == '0; endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("registers not restored");
   c_read: cover property ($fell(rdy_n) && !rd_n);
   c_int: cover property ($fell(int_n));
   c_rst: cover property ($fell(reset_n));
endmodule : hbp_host_port_assertions
bind hbp_host_port hbp_host_port_assertions u_hbp_host_port_assertions (.sys_clk, .sys_rst, .addr, .data_in,
   .data_out, .data_oe, .cs_n, .rd_n, .wr_n, .rdy_n, .int_n, .reset_n, .irq_event, .cmd_regs);

// >>> testbench/hbp_host_model.sv
/* Behavioural host processor on the parallel bus.
   Assumes the bench calls access; pins change on falling edges. */
`timescale 1ns/1ps
module hbp_host_model (
   input  wire logic       sys_clk,
   output logic      [7:0] addr,
   output logic      [7:0] data_in,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   input  wire logic       rdy_n
);
   logic [7:0] wdata = 8'h00;
   logic       drv = 1'b0;
   int         timeouts = 0;
   // A released bus shows the inverse of the last value, never a stale copy
   assign data_in = data_oe ? data_out : (drv ? wdata : ~wdata);
   initial begin
      addr = 8'h00;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
   end
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, input int lag,
                         output logic [7:0] q);
      int n;
      @(negedge sys_clk);
      addr = a;
      wdata = d;
      drv = wr;
      // Address and data must pass the pin synchroniser before the strobe
      repeat (5) @(negedge sys_clk);
      cs_n = 1'b0;
      wr_n = !wr;
      rd_n = wr;
      // Outputs are looked at on falling edges, where they have settled
      for (n = 0; n < 30 && rdy_n !== 1'b0; n++)
         @(negedge sys_clk);
      q = data_in;
      if (rdy_n !== 1'b0)
         timeouts++;
      // Hold the strobe over at least one rising edge that sees ready low
      repeat (lag + 1) @(negedge sys_clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      drv = 1'b0;
      for (n = 0; n < 30 && rdy_n !== 1'b1; n++)
         @(negedge sys_clk);
      if (rdy_n !== 1'b1)
         timeouts++;
   endtask : access
endmodule : hbp_host_model

// >>> testbench/test_host_bus_interrupt_reset_port.sv
/* Self-checking bench for the host bus port.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module test_host_bus_interrupt_reset_port;
   import hbp_pkg::*;
   logic sys_clk = 1'b0, sys_rst = 1'b1, reset_n = 1'b1, data_oe, cs_n, rd_n, wr_n, rdy_n, int_n;
   logic [7:0] addr, data_in, data_out, q, irq_event = 8'h00;
   logic [127:0] cmd_regs, e;
   int fails = 0, checked = 0;
   always #20 sys_clk = ~sys_clk;
   hbp_host_port u_hbp_host_port (.sys_clk, .sys_rst, .addr, .data_in, .data_out, .data_oe, .cs_n, .rd_n,
      .wr_n, .rdy_n, .int_n, .reset_n, .irq_event, .cmd_regs);
   hbp_host_model u_hbp_host_model (.sys_clk, .addr, .data_in, .data_out, .data_oe, .cs_n, .rd_n, .wr_n, .rdy_n);
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic summarize;
      fails += u_hbp_host_model.timeouts;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic t_regs;
      u_hbp_host_model.access(1'b1, 8'h03, 8'hA5, 0, q);
      u_hbp_host_model.access(1'b1, 8'h0D, 8'h5A, 6, q);
      u_hbp_host_model.access(1'b1, 8'h10, 8'hFF, 0, q);
      e = '0;
      e[31:24] = 8'hA5;
      e[111:104] = 8'h5A;
      chk("cmd_regs", e, cmd_regs);
      u_hbp_host_model.access(1'b0, 8'h0D, 8'h00, 3, q);
      chk("read 0D", 8'h5A, q);
      u_hbp_host_model.access(1'b0, 8'h10, 8'h00, 0, q);
      chk("read 10", 8'h00, q);
   endtask : t_regs
   task automatic t_irq;
      u_hbp_host_model.access(1'b1, HBP_OFS_IRQ_EN, 8'h05, 0, q);
      u_hbp_host_model.access(1'b0, HBP_OFS_IRQ_EN, 8'h00, 0, q);
      chk("read enable", 8'h05, q);
      @(negedge sys_clk) irq_event = 8'h02;
      repeat (6) @(negedge sys_clk);
      irq_event = 8'h04;
      repeat (6) @(negedge sys_clk);
      irq_event = 8'h00;
      repeat (4) @(negedge sys_clk);
      chk("int_n set", 1'b0, int_n);
      u_hbp_host_model.access(1'b0, HBP_OFS_IRQ_SRC, 8'h00, 0, q);
      chk("source", 8'h04, q);
      chk("int_n clear", 1'b1, int_n);
   endtask : t_irq
   task automatic t_rst_pin;
      @(negedge sys_clk) reset_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      reset_n = 1'b1;
      chk("regs after pin reset", '0, cmd_regs);
   endtask : t_rst_pin
   initial begin
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk("idle pins", 3'b110, {int_n, rdy_n, data_oe});
      t_regs();
      t_irq();
      t_rst_pin();
      summarize();
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      fails++;
      summarize();
   end
endmodule : test_host_bus_interrupt_reset_port
